// *** common/ssp_pkg.sv ***
// Purpose: Constants for the synchronous serial slave port.
// Assumes: Byte address of each register is four times its index.
// Notes:   Registers are 8 bits wide, held in the low byte of a word.
package ssp_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INT_CTRL  = 8'h0B;
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_RX_STAT   = 8'h18;
	localparam logic [7:0] IDX_TX_HOLD   = 8'h19;
	localparam logic [7:0] IDX_RX_BUF    = 8'h1A;
	localparam logic [7:0] IDX_IRQ_ENS   = 8'h8C;
	localparam logic [7:0] IDX_TX_STAT   = 8'h98;
	localparam logic [7:0] IDX_RATE_DIV  = 8'h99;
	localparam logic [7:0] IDX_EVT_STAT  = 8'hA0;
	localparam logic [7:0] IDX_EVT_CLR   = 8'hA1;
	localparam logic [7:0] IDX_EVT_EN    = 8'hA2;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GLB_IRQ_EN_BIT = 7;
	localparam int PER_IRQ_EN_BIT = 6;
	localparam int RX_FLAG_BIT    = 5;
	localparam int TX_FLAG_BIT    = 4;
	localparam int PORT_EN_BIT    = 7;
	localparam int RX_NINE_BIT    = 6;
	localparam int CONT_RX_BIT    = 4;
	localparam int FRAME_ERR_BIT  = 2;
	localparam int OVERRUN_BIT    = 1;
	localparam int RX_NINTH_BIT   = 0;
	localparam int CLK_SRC_BIT    = 7;
	localparam int TX_NINE_BIT    = 6;
	localparam int TX_EN_BIT      = 5;
	localparam int SYNC_BIT       = 4;
	localparam int TX_EMPTY_BIT   = 1;
	localparam int TX_NINTH_BIT   = 0;
	localparam int EV_TXMOVE      = 0;
	localparam int EV_RXDONE      = 1;
	localparam int EV_OVRUN       = 2;
	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_TX_STAT = 8'h02;
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] TX_STAT_WM  = 8'hF5;
	localparam logic [7:0] RX_STAT_WM  = 8'hF8;
	localparam logic [2:0] EVT_ZERO    = 3'h0;
	localparam logic [3:0] NBITS_8     = 4'h8;
	localparam logic [3:0] NBITS_9     = 4'h9;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
endpackage

// *** rtl/ssp_slave.sv ***
// Purpose: Synchronous serial port, slave side: shift clock comes from the far master.
// Assumes: APB slave, zero wait states; clock and data pins sampled by pclk.
// Notes:   Data leaves LSB first, changed after falling clock edges, sampled on rising.
// Notes on behaviour
// - Slave mode when clock source bit is clear; shift clock comes from the pin.
// - Port keeps shifting from the external clock while the core sleeps.
// - First written word moves straight to the shifter; the second waits in holding.
// - Transmit flag stays clear while holding is full; set once it empties.
// - Enabled transmit flag wakes the core; with global and peripheral enables it takes the vector.
// - Transmit enable set; a holding write starts a transmission.
// - Single-receive enable is ignored in slave mode.
// - Continuous receive captures words in sleep, moves them to buffer, wakes core.
// - Receive flag set when a word is complete; interrupt if enabled.
// - Receive buffer presents the received byte as eight bits.
// - Clearing continuous receive clears the error state.
// - Unimplemented bits read as zero.
//
// Our own choice: the APB slave port.
module ssp_slave #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,        // Bus clock, 10 MHz
	input  wire logic              presetn,     // Async reset, active low
	input  wire logic              psel,        // APB select
	input  wire logic              penable,     // APB access phase
	input  wire logic              pwrite,      // APB write
	input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
	input  wire logic [31:0]       pwdata,      // APB write data
	output logic      [31:0]       prdata,      // APB read data
	output logic                   pready,      // APB ready
	output logic                   pslverr,     // APB error, unmapped address
	input  wire logic              ck_in,       // Clock pin level
	output logic                   ck_out,      // Clock pin drive value
	output logic                   ck_oe,       // Clock pin drive enable
	input  wire logic              dt_in,       // Data pin level
	output logic                   dt_out,      // Data pin drive value
	output logic                   dt_oe,       // Data pin drive enable
	output logic                   core_wake,   // Wake request to the core
	output logic                   core_irq,    // Branch request to the core
	output logic      [12:0]       irq_vector,  // Branch target
	output logic                   irq          // Event interrupt, level
);
	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == ADDR_W'({idx, 2'b00}));
	endfunction

	logic       setup;
	logic       acc;
	logic       mapped;
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] wd;
	logic [7:0] rd_mux;

	assign setup  = psel & ~penable;
	assign acc    = psel & penable;
	assign mapped = hit(paddr, ssp_pkg::IDX_INT_CTRL) | hit(paddr, ssp_pkg::IDX_IRQ_FLAGS)
		| hit(paddr, ssp_pkg::IDX_RX_STAT) | hit(paddr, ssp_pkg::IDX_TX_HOLD)
		| hit(paddr, ssp_pkg::IDX_RX_BUF) | hit(paddr, ssp_pkg::IDX_IRQ_ENS)
		| hit(paddr, ssp_pkg::IDX_TX_STAT) | hit(paddr, ssp_pkg::IDX_RATE_DIV)
		| hit(paddr, ssp_pkg::IDX_EVT_STAT) | hit(paddr, ssp_pkg::IDX_EVT_CLR)
		| hit(paddr, ssp_pkg::IDX_EVT_EN);
	assign wr_acc = acc & pwrite & mapped;
	assign rd_acc = acc & ~pwrite & mapped;
	assign wd     = pwdata[7:0];
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] int_ctrl_r;
	logic [7:0] irq_ens_r;
	logic [7:0] rx_stat_r;
	logic [7:0] tx_stat_r;
	logic [7:0] rate_div_r;
	logic [7:0] hold_r;
	logic       hold_full_r;
	logic [7:0] rx_buf_r;
	logic       rx_ninth_r;
	logic       rx_flag_r;
	logic       overrun_r;
	logic [2:0] evt_stat_r;
	logic [2:0] evt_en_r;
	logic [2:0] evt_set;
	logic [8:0] tx_shift_r;
	logic [3:0] tx_cnt_r;
	logic [8:0] rx_shift_r;
	logic [3:0] rx_cnt_r;
	logic [8:0] rx_word;
	logic       active;
	logic       tx_flag;
	logic       tx_empty;
	logic       tx_load;
	logic       rx_on;
	logic       rx_done;
	logic [3:0] tx_nbits;
	logic [3:0] rx_nbits;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_ctrl_r <= ssp_pkg::RST_ZERO;
			irq_ens_r  <= ssp_pkg::RST_ZERO;
			rate_div_r <= ssp_pkg::RST_ZERO;
			rx_stat_r  <= ssp_pkg::RST_ZERO;
			tx_stat_r  <= ssp_pkg::RST_TX_STAT;
			evt_en_r   <= ssp_pkg::EVT_ZERO;
		end else if (wr_acc) begin
			if (hit(paddr, ssp_pkg::IDX_INT_CTRL)) begin
				int_ctrl_r <= wd;
			end
			if (hit(paddr, ssp_pkg::IDX_IRQ_ENS)) begin
				irq_ens_r <= wd;
			end
			if (hit(paddr, ssp_pkg::IDX_RATE_DIV)) begin
				rate_div_r <= wd;
			end
			if (hit(paddr, ssp_pkg::IDX_RX_STAT)) begin
				rx_stat_r <= wd & ssp_pkg::RX_STAT_WM;
			end
			if (hit(paddr, ssp_pkg::IDX_TX_STAT)) begin
				tx_stat_r <= wd & ssp_pkg::TX_STAT_WM;
			end
			if (hit(paddr, ssp_pkg::IDX_EVT_EN)) begin
				evt_en_r <= wd[2:0];
			end
		end
	end

	// Slave only when clock source is external; master mode leaves the port idle
	assign active = rx_stat_r[ssp_pkg::PORT_EN_BIT] & tx_stat_r[ssp_pkg::SYNC_BIT]
		& ~tx_stat_r[ssp_pkg::CLK_SRC_BIT];
	assign tx_nbits = tx_stat_r[ssp_pkg::TX_NINE_BIT] ? ssp_pkg::NBITS_9
		: ssp_pkg::NBITS_8;
	assign rx_nbits = rx_stat_r[ssp_pkg::RX_NINE_BIT] ? ssp_pkg::NBITS_9
		: ssp_pkg::NBITS_8;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic ck_s1;
	logic ck_s2;
	logic ck_s3;
	logic dt_s1;
	logic dt_s2;
	logic ck_rise;
	logic ck_fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			dt_s1 <= 1'b0;
			dt_s2 <= 1'b0;
		end else begin
			ck_s1 <= ck_in;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			dt_s1 <= dt_in;
			dt_s2 <= dt_s1;
		end
	end

	// Edges come only from the pin, so shifting runs with the core asleep
	assign ck_rise = ck_s2 & ~ck_s3;
	assign ck_fall = ~ck_s2 & ck_s3;
	assign ck_out  = 1'b0;
	assign ck_oe   = 1'b0;

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	assign tx_empty = (tx_cnt_r == 4'h0);
	// Receive enable owns the data pin, so transmit waits while it is set
	assign tx_load  = active & tx_stat_r[ssp_pkg::TX_EN_BIT]
		& ~rx_stat_r[ssp_pkg::CONT_RX_BIT] & hold_full_r & tx_empty;
	assign tx_flag  = tx_stat_r[ssp_pkg::TX_EN_BIT] & ~hold_full_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r      <= ssp_pkg::RST_ZERO;
			hold_full_r <= 1'b0;
		end else if (wr_acc && hit(paddr, ssp_pkg::IDX_TX_HOLD)) begin
			hold_r      <= wd;
			hold_full_r <= 1'b1;
		end else if (tx_load) begin
			hold_full_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_shift_r <= 9'h000;
			tx_cnt_r   <= 4'h0;
			dt_out     <= 1'b0;
		end else if (!active || !tx_stat_r[ssp_pkg::TX_EN_BIT]) begin
			tx_cnt_r   <= 4'h0;
		end else if (tx_load) begin
			tx_shift_r <= {tx_stat_r[ssp_pkg::TX_NINTH_BIT], hold_r};
			tx_cnt_r   <= tx_nbits;
			dt_out     <= hold_r[0];
		end else if (ck_fall && !tx_empty) begin
			tx_shift_r <= {1'b0, tx_shift_r[8:1]};
			tx_cnt_r   <= tx_cnt_r - 4'h1;
			dt_out     <= tx_shift_r[1];
		end
	end

	assign dt_oe = ~tx_empty;

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	// Single-receive enable never enters this term
	assign rx_on   = active & rx_stat_r[ssp_pkg::CONT_RX_BIT] & ~overrun_r;
	assign rx_done = rx_on & ck_rise & (rx_cnt_r == rx_nbits - 4'h1);

	always_comb begin
		rx_word           = rx_shift_r;
		rx_word[rx_cnt_r] = dt_s2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_shift_r <= 9'h000;
			rx_cnt_r   <= 4'h0;
		end else if (!rx_on) begin
			rx_cnt_r   <= 4'h0;
		end else if (rx_done) begin
			rx_shift_r <= 9'h000;
			rx_cnt_r   <= 4'h0;
		end else if (ck_rise) begin
			rx_shift_r <= rx_word;
			rx_cnt_r   <= rx_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_r   <= ssp_pkg::RST_ZERO;
			rx_ninth_r <= 1'b0;
		end else if (rx_done && !rx_flag_r) begin
			rx_buf_r   <= rx_word[7:0];
			rx_ninth_r <= rx_word[8];
		end
	end

	// Buffer read clears the flag; a word landing in that cycle is lost as an overrun
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_flag_r <= 1'b0;
		end else if (rx_done && !rx_flag_r) begin
			rx_flag_r <= 1'b1;
		end else if (rd_acc && hit(paddr, ssp_pkg::IDX_RX_BUF)) begin
			rx_flag_r <= 1'b0;
		end
	end

	// Unread buffer at word end loses the word and halts reception
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_r <= 1'b0;
		end else if (rx_done && rx_flag_r) begin
			overrun_r <= 1'b1;
		end else if (!rx_stat_r[ssp_pkg::CONT_RX_BIT]) begin
			overrun_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Events and core wake
	// ----------------------------------------------------------------
	assign evt_set = {rx_done & rx_flag_r, rx_done & ~rx_flag_r, tx_load};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_stat_r <= ssp_pkg::EVT_ZERO;
		end else if (wr_acc && hit(paddr, ssp_pkg::IDX_EVT_CLR)) begin
			evt_stat_r <= (evt_stat_r & ~wd[2:0]) | evt_set;
		end else begin
			evt_stat_r <= evt_stat_r | evt_set;
		end
	end

	assign irq        = |(evt_stat_r & evt_en_r);
	assign core_wake  = (tx_flag & irq_ens_r[ssp_pkg::TX_FLAG_BIT])
		| (rx_flag_r & irq_ens_r[ssp_pkg::RX_FLAG_BIT]);
	assign core_irq   = core_wake & int_ctrl_r[ssp_pkg::GLB_IRQ_EN_BIT]
		& int_ctrl_r[ssp_pkg::PER_IRQ_EN_BIT];
	assign irq_vector = ssp_pkg::IRQ_VECTOR;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = ssp_pkg::RST_ZERO;
		if (hit(paddr, ssp_pkg::IDX_INT_CTRL)) begin
			rd_mux = int_ctrl_r;
		end
		if (hit(paddr, ssp_pkg::IDX_IRQ_FLAGS)) begin
			rd_mux = {2'b00, rx_flag_r, tx_flag, 4'h0};
		end
		if (hit(paddr, ssp_pkg::IDX_RX_STAT)) begin
			rd_mux = {rx_stat_r[7:3], 1'b0, overrun_r, rx_ninth_r};
		end
		if (hit(paddr, ssp_pkg::IDX_RX_BUF)) begin
			rd_mux = rx_buf_r;
		end
		if (hit(paddr, ssp_pkg::IDX_IRQ_ENS)) begin
			rd_mux = irq_ens_r;
		end
		if (hit(paddr, ssp_pkg::IDX_TX_STAT)) begin
			rd_mux = {tx_stat_r[7:4], 1'b0, tx_stat_r[2], tx_empty, tx_stat_r[0]};
		end
		if (hit(paddr, ssp_pkg::IDX_RATE_DIV)) begin
			rd_mux = rate_div_r;
		end
		if (hit(paddr, ssp_pkg::IDX_EVT_STAT)) begin
			rd_mux = {5'h00, evt_stat_r};
		end
		if (hit(paddr, ssp_pkg::IDX_EVT_EN)) begin
			rd_mux = {5'h00, evt_en_r};
		end
	end

	// Captured in setup so the answer comes from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= {24'h00_0000, rd_mux};
			pslverr <= ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_clk_pin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!ck_oe)
		else $error("Clock pin driven");
	// Counters clear one cycle after the port goes inactive
	chk_master_idle: assert property (@(posedge pclk) disable iff (!presetn)
		tx_stat_r[ssp_pkg::CLK_SRC_BIT] |=> (tx_empty && rx_cnt_r == 4'h0))
		else $error("Port active with internal clock source");
	chk_load_first: assert property (@(posedge pclk) disable iff (!presetn)
		tx_load |=> (!tx_empty && tx_shift_r[7:0] == $past(hold_r)))
		else $error("Holding word not moved into shifter");
	chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		hold_full_r |-> !tx_flag)
		else $error("Transmit flag set with holding full");
	chk_second_move: assert property (@(posedge pclk) disable iff (!presetn)
		(hold_full_r && !tx_empty && ck_fall && tx_cnt_r == 4'h1
		&& active && !rx_stat_r[ssp_pkg::CONT_RX_BIT]
		&& tx_stat_r[ssp_pkg::TX_EN_BIT]) |=> tx_load ##1 tx_flag || hold_full_r)
		else $error("Second word not moved after first");
	chk_wake_branch: assert property (@(posedge pclk) disable iff (!presetn)
		core_irq |-> (core_wake && int_ctrl_r[ssp_pkg::GLB_IRQ_EN_BIT])
		&& irq_vector == 13'h0004)
		else $error("Branch without wake or global enable");
	chk_tx_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_stat_r[ssp_pkg::TX_EN_BIT] && !hold_full_r
		&& irq_ens_r[ssp_pkg::TX_FLAG_BIT]) |-> core_wake)
		else $error("Enabled transmit flag did not wake");
	chk_rx_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_done && !rx_flag_r) |=> (rx_flag_r && rx_buf_r == $past(rx_word[7:0])))
		else $error("Received word not posted");
	chk_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
		!rx_stat_r[ssp_pkg::CONT_RX_BIT] |=> !overrun_r)
		else $error("Error not cleared by receive disable");
	chk_empty_state: assert property (@(posedge pclk) disable iff (!presetn)
		tx_load |=> !tx_empty [*2])
		else $error("Shifter empty during transmission");

	cov_tx_word: cover property (@(posedge pclk) disable iff (!presetn)
		tx_load ##[1:300] tx_empty);
	cov_rx_word: cover property (@(posedge pclk) disable iff (!presetn) rx_done && !rx_flag_r);
	cov_overrun: cover property (@(posedge pclk) disable iff (!presetn) rx_done && rx_flag_r);
	cov_two_words: cover property (@(posedge pclk) disable iff (!presetn)
		tx_load ##1 hold_full_r);
endmodule

// *** sim/ssp_master_model.sv ***
// Purpose: Far-side synchronous serial master that makes the shift clock.
// Assumes: Clock idles low; data toward the slave changes while the clock is low.
// Notes:   Outside frames the data line toggles so a stale bit never passes as valid.
module ssp_master_model (
	output logic      ck_m,    // Shift clock toward the slave
	output logic      dt_m,    // Data toward the slave
	input  wire logic dt_line  // Resolved data pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy;

	initial begin
		ck_m = 1'b0;
		dt_m = 1'b0;
		busy = 1'b0;
	end

	// Released line: changing pattern, not the last bit
	always #130 if (!busy) dt_m = ~dt_m;

	// ----------------------------------------------------------------
	// One frame of n bits, LSB first, 800 ns per bit
	// ----------------------------------------------------------------
	task automatic shift(input int n, input logic [8:0] tx, output logic [8:0] rx);
		busy = 1'b1;
		rx = 9'h000;
		#37;
		for (int i = 0; i < n; i++) begin
			dt_m = tx[i];
			#400;
			ck_m = 1'b1;
			rx[i] = dt_line;
			#400;
			ck_m = 1'b0;
		end
		// Slave needs a few bus clocks to see the last fall
		#800;
		busy = 1'b0;
	endtask
endmodule

// *** sim/tb_sync_serial_slave_port.sv ***
// Purpose: Self-checking bench for the synchronous serial slave port.
// Assumes: APB master in the bench, serial master model on the link.
// Notes:   Link clock stands low between frames.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_sync_serial_slave_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, ck_out, ck_oe, dt_out, dt_oe;
	logic        core_wake, core_irq, irq, ck_m, dt_m, er;
	logic [12:0] irq_vector;
	wire logic   ck_pin, dt_pin;
	logic [8:0]  rxw;
	logic [7:0]  rd;
	int          err_count, cmp_count;

	assign ck_pin = ck_oe ? ck_out : ck_m;
	assign dt_pin = dt_oe ? dt_out : dt_m;

	ssp_slave #(.ADDR_W(12)) ssp_slave_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ck_in(ck_pin), .ck_out(ck_out),
		.ck_oe(ck_oe), .dt_in(dt_pin), .dt_out(dt_out), .dt_oe(dt_oe),
		.core_wake(core_wake), .core_irq(core_irq), .irq_vector(irq_vector), .irq(irq)
	);

	ssp_master_model ssp_master_model_inst (.ck_m(ck_m), .dt_m(dt_m), .dt_line(dt_pin));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// APB transfer; results settle before the next check
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// Wait as long as the slave asks; only the watchdog ends a hang
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(idx, 1'b1, d);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
		xfer(idx, 1'b0, 8'h00);
		`CHK(nm, e, rd)
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#5000000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		err_count = 0;
		cmp_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ssp_pkg::IDX_TX_STAT, 8'h02, "tx_stat_reset");
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h00, "flags_reset");
		rchk(ssp_pkg::IDX_RX_BUF, 8'h00, "rx_buf_reset");
		xfer(8'h50, 1'b0, 8'h00);
		`CHK("unmapped_err", 1'b1, er)
		wr(ssp_pkg::IDX_TX_STAT, 8'hFF);
		rchk(ssp_pkg::IDX_TX_STAT, 8'hF7, "tx_stat_unimpl");
		$display("Test registers done");
		// Slave transmit setup: clock from pin, receive off
		wr(ssp_pkg::IDX_RX_STAT, 8'h80);
		wr(ssp_pkg::IDX_TX_STAT, 8'h30);
		wr(ssp_pkg::IDX_INT_CTRL, 8'hC0);
		wr(ssp_pkg::IDX_IRQ_ENS, 8'h10);
		wr(ssp_pkg::IDX_EVT_EN, 8'h07);
		wr(ssp_pkg::IDX_TX_HOLD, 8'h3C);
		wr(ssp_pkg::IDX_TX_HOLD, 8'hC5);
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h00, "tx_flag_held");
		`CHK("wake_held", 1'b0, core_wake)
		rchk(ssp_pkg::IDX_TX_STAT, 8'h30, "empty_busy");
		ssp_master_model_inst.shift(8, 9'h000, rxw);
		`CHK("tx_first", 8'h3C, rxw[7:0])
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h10, "tx_flag_set");
		`CHK("wake", 1'b1, core_wake)
		`CHK("branch", 1'b1, core_irq)
		`CHK("vector", 13'h0004, irq_vector)
		`CHK("ck_drive", 1'b0, ck_oe)
		`CHK("ck_level", 1'b0, ck_out)
		ssp_master_model_inst.shift(8, 9'h000, rxw);
		`CHK("tx_second", 8'hC5, rxw[7:0])
		rchk(ssp_pkg::IDX_TX_STAT, 8'h32, "empty_idle");
		`CHK("dt_released", 1'b0, dt_oe)
		rchk(ssp_pkg::IDX_EVT_STAT, 8'h01, "evt_tx");
		`CHK("irq_on", 1'b1, irq)
		wr(ssp_pkg::IDX_EVT_EN, 8'h00);
		`CHK("irq_masked", 1'b0, irq)
		wr(ssp_pkg::IDX_EVT_EN, 8'h07);
		wr(ssp_pkg::IDX_EVT_CLR, 8'h07);
		rchk(ssp_pkg::IDX_EVT_STAT, 8'h00, "evt_clr");
		`CHK("irq_clr", 1'b0, irq)
		// Nine bits: ninth bit set before the data word
		wr(ssp_pkg::IDX_TX_STAT, 8'h71);
		wr(ssp_pkg::IDX_TX_HOLD, 8'hA6);
		ssp_master_model_inst.shift(9, 9'h000, rxw);
		`CHK("tx_nine", 9'h1A6, rxw)
		$display("Test transmit done");
		// Receive: single-receive bit set too, it must not matter
		wr(ssp_pkg::IDX_TX_STAT, 8'h10);
		wr(ssp_pkg::IDX_IRQ_ENS, 8'h20);
		wr(ssp_pkg::IDX_RX_STAT, 8'hB0);
		ssp_master_model_inst.shift(8, 9'h0A5, rxw);
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h20, "rx_flag_set");
		`CHK("rx_wake", 1'b1, core_wake)
		rchk(ssp_pkg::IDX_RX_STAT, 8'hB0, "rx_stat_ok");
		rchk(ssp_pkg::IDX_RX_BUF, 8'hA5, "rx_byte");
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h00, "rx_flag_clr");
		ssp_master_model_inst.shift(8, 9'h05A, rxw);
		ssp_master_model_inst.shift(8, 9'h069, rxw);
		rchk(ssp_pkg::IDX_RX_STAT, 8'hB2, "overrun");
		rchk(ssp_pkg::IDX_RX_BUF, 8'h5A, "rx_kept");
		wr(ssp_pkg::IDX_RX_STAT, 8'hA0);
		rchk(ssp_pkg::IDX_RX_STAT, 8'hA0, "err_cleared");
		ssp_master_model_inst.shift(8, 9'h077, rxw);
		rchk(ssp_pkg::IDX_IRQ_FLAGS, 8'h00, "single_rx_ignored");
		wr(ssp_pkg::IDX_RX_STAT, 8'hD0);
		ssp_master_model_inst.shift(9, 9'h13C, rxw);
		rchk(ssp_pkg::IDX_RX_STAT, 8'hD1, "rx_ninth");
		rchk(ssp_pkg::IDX_RX_BUF, 8'h3C, "rx_nine_byte");
		$display("Test receive done");
		tally_and_finish();
	end
endmodule
